// file: bench/tb.sv
`timescale 1ns/1ps
// ==========================================
// Bench for the enable mask and interrupt
module tb;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  tmie_pkg::tmie_bus_req_s req = '0;
  tmie_pkg::tmie_evt_s ev = '0;
  logic [31:0] RDATA;
  tmie_pkg::tmie_evt_s IRQ_ENABLE;
  logic IRQ;
  int checks = 0;
  int mismatches = 0;
  int bp[7] = '{1, 9, 18, 19, 20, 23, 24};
  tmie_irq_enable dut_u (.CLK(CLK), .RST(RST), .BUS_REQ(req), .RDATA(RDATA), .EVENTS(ev),
    .IRQ_ENABLE(IRQ_ENABLE), .IRQ(IRQ));
  // Free-running 50 MHz clock
  always #10 CLK = ~CLK;
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x)
    begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, s, x);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge CLK);
    req.wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    @(posedge CLK);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge CLK);
    req.rd <= 1'b0;
    #1 chk(RDATA, x);
  endtask
  // Each enable set, then cleared, one at a time
  task automatic t_set_clear;
    logic [31:0] acc;
    acc = 32'h0;
    chk({25'h0, IRQ_ENABLE}, 32'h0);
    for (int i = 0; i < 7; i++)
    begin
      wr(12'h304, 32'h1 << bp[i]);
      acc[bp[i]] = 1'b1;
      rd(12'h304, acc);
    end
    wr(12'h304, 32'h0);
    wr(12'h308, 32'h0);
    rd(12'h308, acc);
    for (int i = 0; i < 7; i++)
    begin
      wr(12'h308, 32'h1 << bp[i]);
      acc[bp[i]] = 1'b0;
      rd(12'h308, acc);
    end
    $display("done set_clear");
  endtask
  // Plain writes keep only the seven enable bits
  task automatic t_direct;
    wr(12'h300, 32'hffffffff);
    rd(12'h300, 32'h019c0202);
    wr(12'h300, 32'h00000200);
    rd(12'h304, 32'h00000200);
    rd(12'h3fc, 32'h0);
    $display("done direct");
  endtask
  // Sticky event survives masking, so unmasking raises it again
  task automatic t_irq;
    wr(12'h300, 32'h2);
    @(posedge CLK);
    ev <= 7'h01;
    @(posedge CLK);
    ev <= 7'h00;
    #1 chk(32'(IRQ), 32'h0);
    @(posedge CLK);
    #1 chk(32'(IRQ), 32'h1);
    rd(12'h310, 32'h2);
    wr(12'h308, 32'h2);
    @(posedge CLK);
    #1 chk(32'(IRQ), 32'h0);
    wr(12'h304, 32'h2);
    @(posedge CLK);
    #1 chk(32'(IRQ), 32'h1);
    wr(12'h310, 32'h2);
    @(posedge CLK);
    #1 chk(32'(IRQ), 32'h0);
    $display("done irq");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence after an 8-cycle reset
  initial
  begin
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    t_set_clear();
    t_direct();
    t_irq();
    conclude();
  end
  // Watchdog against a hung run
  initial
  begin
    #100000;
    mismatches++;
    conclude();
  end
endmodule

// file: bench/tmie_irq_enable_asserts.sv
`timescale 1ns/1ps
// ==========================================
// Checker on the enable mask and interrupt
module tmie_irq_enable_asserts (
  input wire logic CLK, // Clock
  input wire logic RST, // Reset
  input wire tmie_pkg::tmie_bus_req_s BUS_REQ, // Bus
  input wire logic [31:0] RDATA, // Read data
  input wire tmie_pkg::tmie_evt_s EVENTS, // Events
  input wire tmie_pkg::tmie_evt_s IRQ_ENABLE, // Mask
  input wire logic IRQ // Interrupt
);
  // Word bits 1, 9, 18..20, 23 and 24 carry the seven enables
  function automatic logic [6:0] pk(input logic [31:0] w);
    return {w[24], w[23], w[20:18], w[9], w[1]};
  endfunction
  function automatic logic [31:0] ex(input logic [6:0] m);
    return {7'h00, m[6:5], 2'h0, m[4:2], 8'h00, m[1], 7'h00, m[0], 1'h0};
  endfunction
  // Short views of the port fields
  wire [11:0] a = BUS_REQ.addr;
  wire [31:0] d = BUS_REQ.wdata;
  wire [6:0] m = IRQ_ENABLE;
  wire [6:0] e = EVENTS;
  wire wr = BUS_REQ.wr;
  wire rd = BUS_REQ.rd;
  wire mw = wr && a inside {12'h300, 12'h304, 12'h308};
  wire mr = rd && a inside {12'h300, 12'h304, 12'h308};
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_set_ors: assert property (wr && a == 12'h304 |=> m == ($past(m) | pk($past(d))))
    else $error("set write wrong");
  a_clr_ands: assert property (wr && a == 12'h308 |=> m == ($past(m) & ~pk($past(d))))
    else $error("clear write wrong");
  a_direct_write: assert property (wr && a == 12'h300 |=> m == pk($past(d)))
    else $error("direct write wrong");
  a_mask_hold: assert property (!mw |=> m == $past(m))
    else $error("mask moved");
  a_read_mask: assert property (mr |=> RDATA == ex($past(m)))
    else $error("mask read wrong");
  a_rdata_idle: assert property (!rd |=> RDATA == 32'h0)
    else $error("read data not idle");
  a_irq_rise: assert property ((|(e & m)) && !wr ##1 !wr |=> IRQ)
    else $error("interrupt missing");
  a_irq_cause: assert property ($rose(IRQ) |-> $past(m) != 7'h00)
    else $error("interrupt while masked");
  a_irq_off: assert property (m == 7'h00 |=> !IRQ)
    else $error("interrupt with empty mask");
  cover property (mw);
  cover property (rd ##1 RDATA != 32'h0);
  cover property ($rose(IRQ));
endmodule
bind tmie_irq_enable tmie_irq_enable_asserts chk_u (.CLK, .RST, .BUS_REQ, .RDATA, .EVENTS,
  .IRQ_ENABLE, .IRQ);

// file: hdl/tmie_defs.svh
`ifndef TMIE_DEFS_SVH
`define TMIE_DEFS_SVH

// ==========================================================
// Register byte offsets
`define TMIE_OFF_ENABLE_DIRECT 12'h300
`define TMIE_OFF_ENABLE_SET 12'h304
`define TMIE_OFF_ENABLE_CLEAR 12'h308
`define TMIE_OFF_EVENT_STATUS 12'h310

// ==========================================================
// Bit positions of the seven events in every register word
`define TMIE_BIT_HALT_DONE 1
`define TMIE_BIT_FAULT 9
`define TMIE_BIT_PAUSED 18
`define TMIE_BIT_RECEIVE_BEGUN 19
`define TMIE_BIT_TRANSMIT_BEGUN 20
`define TMIE_BIT_FINAL_RECEIVE_BYTE 23
`define TMIE_BIT_FINAL_TRANSMIT_BYTE 24

// ==========================================================
// Reset values
`define TMIE_RST_ENABLE 7'h00
`define TMIE_RST_STATUS 7'h00
`define TMIE_RST_WORD 32'h00000000

`endif

// file: hdl/tmie_irq_enable.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "tmie_defs.svh"

// ==========================================================
// Sticky flag cell: one per event, the set pulse wins over a clear
module tmie_flag_cell #(
  parameter logic RST_VAL = 1'h0 // Flag value after reset
) (
  input wire logic clk, // Block clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic set_pulse, // One-cycle event pulse
  input wire logic clear_one, // Write-one clear for this flag
  output logic flag // Sticky flag
);

  logic flag_reg;

  // A pulse in the clearing cycle keeps the flag, so no event is lost
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flag_reg <= RST_VAL;
    else if (set_pulse)
      flag_reg <= 1'h1;
    else if (clear_one)
      flag_reg <= 1'h0;
  end

  assign flag = flag_reg;

endmodule

module tmie_irq_enable (
  input wire logic CLK, // 50 MHz peripheral clock
  input wire logic RST, // Asynchronous reset, active high
  input wire tmie_pkg::tmie_bus_req_s BUS_REQ, // Address, data and strobes
  output logic [31:0] RDATA, // Read data, cycle after the read strobe
  input wire tmie_pkg::tmie_evt_s EVENTS, // One-cycle event pulses, same clock
  output tmie_pkg::tmie_evt_s IRQ_ENABLE, // Current enable mask
  output logic IRQ // Level interrupt to the core
);

  // ==========================================================
  // Register map and timing at a glance
  //
  // Offset 0x300: enable mask, plain read and write
  // Offset 0x304: enable mask, ones written set bits
  // Offset 0x308: enable mask, ones written clear bits
  // Offset 0x310: sticky event flags, ones written clear flags
  //
  // All three enable views read back the same mask word.
  // Only bits 1, 9, 18, 19, 20, 23 and 24 are implemented;
  // every other bit reads zero and ignores what is written.
  //
  // Writes take effect at the edge that samples the strobe.
  // Read data stand in the cycle after the read strobe only,
  // and read zero in every other cycle, so a bus mux upstream
  // may simply OR several slaves together.
  //
  // An event pulse sets its flag at the next edge, and the
  // interrupt follows one edge later. The extra flop costs a
  // cycle of latency but keeps the interrupt line glitch free.
  //
  // Limitation: the block never stalls the bus, and a write and
  // a read in one cycle are not supported by the bus master.

  // ==========================================================
  // Word <-> compact event vector mapping

  // Gathers the seven event bits out of a bus word
  function automatic logic [6:0] word_to_evt(input logic [31:0] w);
    logic [6:0] v;
    v = 7'h00;
    v[0] = w[`TMIE_BIT_HALT_DONE];
    v[1] = w[`TMIE_BIT_FAULT];
    v[2] = w[`TMIE_BIT_PAUSED];
    v[3] = w[`TMIE_BIT_RECEIVE_BEGUN];
    v[4] = w[`TMIE_BIT_TRANSMIT_BEGUN];
    v[5] = w[`TMIE_BIT_FINAL_RECEIVE_BYTE];
    v[6] = w[`TMIE_BIT_FINAL_TRANSMIT_BYTE];
    return v;
  endfunction

  // Spreads the seven bits back to their word positions, others zero
  function automatic logic [31:0] evt_to_word(input logic [6:0] v);
    logic [31:0] w;
    w = `TMIE_RST_WORD;
    w[`TMIE_BIT_HALT_DONE] = v[0];
    w[`TMIE_BIT_FAULT] = v[1];
    w[`TMIE_BIT_PAUSED] = v[2];
    w[`TMIE_BIT_RECEIVE_BEGUN] = v[3];
    w[`TMIE_BIT_TRANSMIT_BEGUN] = v[4];
    w[`TMIE_BIT_FINAL_RECEIVE_BYTE] = v[5];
    w[`TMIE_BIT_FINAL_TRANSMIT_BYTE] = v[6];
    return w;
  endfunction

  // ==========================================================
  // Address decode
  logic [6:0] wbits;
  logic wr_direct;
  logic wr_set;
  logic wr_clear;
  logic wr_status;

  // Strobes qualified by exact offset; other addresses are ignored
  assign wbits = word_to_evt(BUS_REQ.wdata);
  assign wr_direct = BUS_REQ.wr && (BUS_REQ.addr == `TMIE_OFF_ENABLE_DIRECT);
  assign wr_set = BUS_REQ.wr && (BUS_REQ.addr == `TMIE_OFF_ENABLE_SET);
  assign wr_clear = BUS_REQ.wr && (BUS_REQ.addr == `TMIE_OFF_ENABLE_CLEAR);
  assign wr_status = BUS_REQ.wr && (BUS_REQ.addr == `TMIE_OFF_EVENT_STATUS);

  // ==========================================================
  // Shared enable mask
  logic [6:0] enable_reg;
  logic [6:0] enable_next;

  // One mask serves all three views, so set and clear never disagree
  always_comb
  begin
    enable_next = enable_reg;
    if (wr_direct)
    begin
      enable_next = wbits;
    end
    if (wr_set)
    begin
      enable_next = enable_reg | wbits;
    end
    if (wr_clear)
    begin
      enable_next = enable_reg & ~wbits;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      enable_reg <= `TMIE_RST_ENABLE;
    else
      enable_reg <= enable_next;
  end

  // ==========================================================
  // Sticky event flags, cleared by writing one
  logic [6:0] status_reg;

  // One cell per event; each flag bit has exactly one driver
  tmie_flag_cell #(
    .RST_VAL(1'h0)
  ) flag_halt_done_u (
    .clk(CLK),
    .rst(RST),
    .set_pulse(EVENTS.halt_done_event),
    .clear_one(wr_status && wbits[0]),
    .flag(status_reg[0])
  );

  // Fault flag
  tmie_flag_cell #(
    .RST_VAL(1'h0)
  ) flag_fault_u (
    .clk(CLK),
    .rst(RST),
    .set_pulse(EVENTS.fault_event),
    .clear_one(wr_status && wbits[1]),
    .flag(status_reg[1])
  );

  // Paused flag
  tmie_flag_cell #(
    .RST_VAL(1'h0)
  ) flag_paused_u (
    .clk(CLK),
    .rst(RST),
    .set_pulse(EVENTS.paused_event),
    .clear_one(wr_status && wbits[2]),
    .flag(status_reg[2])
  );

  // Receive-begun flag
  tmie_flag_cell #(
    .RST_VAL(1'h0)
  ) flag_receive_begun_u (
    .clk(CLK),
    .rst(RST),
    .set_pulse(EVENTS.receive_begun_event),
    .clear_one(wr_status && wbits[3]),
    .flag(status_reg[3])
  );

  // Transmit-begun flag
  tmie_flag_cell #(
    .RST_VAL(1'h0)
  ) flag_transmit_begun_u (
    .clk(CLK),
    .rst(RST),
    .set_pulse(EVENTS.transmit_begun_event),
    .clear_one(wr_status && wbits[4]),
    .flag(status_reg[4])
  );

  // Final-receive-byte flag
  tmie_flag_cell #(
    .RST_VAL(1'h0)
  ) flag_final_receive_byte_u (
    .clk(CLK),
    .rst(RST),
    .set_pulse(EVENTS.final_receive_byte_event),
    .clear_one(wr_status && wbits[5]),
    .flag(status_reg[5])
  );

  // Final-transmit-byte flag
  tmie_flag_cell #(
    .RST_VAL(1'h0)
  ) flag_final_transmit_byte_u (
    .clk(CLK),
    .rst(RST),
    .set_pulse(EVENTS.final_transmit_byte_event),
    .clear_one(wr_status && wbits[6]),
    .flag(status_reg[6])
  );

  // ==========================================================
  // Interrupt output, registered for a clean level
  logic irq_reg;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      irq_reg <= 1'h0;
    else
      irq_reg <= |(status_reg & enable_reg);
  end

  // ==========================================================
  // Read path: data valid only in the cycle after the strobe
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // Unmapped offsets read zero; all three enable views show the mask
  always_comb
  begin
    rdata_next = `TMIE_RST_WORD;
    if (BUS_REQ.rd)
    begin
      case (BUS_REQ.addr)
        `TMIE_OFF_ENABLE_DIRECT,
        `TMIE_OFF_ENABLE_SET,
        `TMIE_OFF_ENABLE_CLEAR: rdata_next = evt_to_word(enable_reg);
        `TMIE_OFF_EVENT_STATUS: rdata_next = evt_to_word(status_reg);
        default: rdata_next = `TMIE_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      rdata_reg <= `TMIE_RST_WORD;
    else
      rdata_reg <= rdata_next;
  end

  // Mask copy out, one flop each, same timing as the internal mask
  tmie_pkg::tmie_evt_s enable_out_reg;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      enable_out_reg <= tmie_pkg::tmie_evt_s'(`TMIE_RST_ENABLE);
    else
      enable_out_reg <= tmie_pkg::tmie_evt_s'(enable_next);
  end

  assign RDATA = rdata_reg;
  assign IRQ = irq_reg;
  assign IRQ_ENABLE = enable_out_reg;

endmodule

// file: hdl/tmie_pkg.sv
package tmie_pkg;

  // ==========================================================
  // Seven events, one bit each, compact internal order
  typedef struct packed {
    logic final_transmit_byte_event;
    logic final_receive_byte_event;
    logic transmit_begun_event;
    logic receive_begun_event;
    logic paused_event;
    logic fault_event;
    logic halt_done_event;
  } tmie_evt_s;

  // ==========================================================
  // Register port request from software
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tmie_bus_req_s;

endpackage
